// ---- core/brs_sequencer.sv ----
// backup, restore and session access sequencer with avalon register slave
`timescale 1ns/1ns

// Notes on behaviour
// - module at power-up: halt, fault, accept commands
// - fault indicators: power, red fault, lock green
// - verified cycles digits, else fixed pattern
// - backup only from verified configuration
// - held button starts backup, status flashes
// - unverified request: steady status after 15 s
// - both buttons held 5 s start restore
// - restore runs on after button release
// - restore done: stop flashing, cycle digits
// - stored password mismatch blocks restore
// - firmware plus project only from software
// - operations only with module in slot 1
// - password set: new session must supply it
// - password settable in program or run
// - changed password demanded from later sessions
// - cleared password admits sessions freely
// - firmware refresh erases project and password
// - one session holds exclusive access; firmware refresh is taken from any session id and ends the owning session
module brs_sequencer
   import brs_pkg::*;
#(
   parameter int unsigned REFUSE_T   = REFUSE_CYC,
   parameter int unsigned RESTORE_T  = RESTORE_CYC,
   parameter int unsigned DEBOUNCE_T = DEBOUNCE_CYC,
   parameter int unsigned DIGIT_T    = DIGIT_CYC,
   parameter int unsigned BLINK_T    = BLINK_CYC
) (
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic [ADDR_W-1:0] avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   output logic      [31:0]       avs_readdata,
   output logic                   avs_waitrequest,
   input  wire logic              backup_button,
   input  wire logic              restore_select_button,
   input  wire logic              slot1_present,
   input  wire logic              mod_pw_match,
   input  wire logic              mod_done,
   input  wire logic              cfg_verified,
   output logic                   mod_backup_req,
   output logic                   mod_restore_req,
   output logic                   mod_fw_incl,
   output logic                   mod_status_led,
   output logic                   power_indicator,
   output logic                   run_indicator,
   output logic                   fault_indicator,
   output logic                   lock_indicator,
   output logic                   link_activity_indicator,
   output logic      [IN_W-1:0]   in_indicator,
   output logic      [OUT_W-1:0]  out_indicator,
   output logic                   app_run,
   output logic                   project_erase
);
   // ********************************************************
   // pin synchronisers and button debounce
   // ********************************************************
   localparam int unsigned NPIN = 5;
   logic [NPIN-1:0]  pin_raw;
   logic [NPIN-1:0]  meta_reg;
   logic [NPIN-1:0]  sync_reg;
   logic [1:0]       deb_reg;
   logic [CNT_W-1:0] deb_cnt_reg [2];

   assign pin_raw = {mod_done, mod_pw_match, slot1_present,
                     restore_select_button, backup_button};

   // first stage feeds only the second stage
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= pin_raw;
         sync_reg <= meta_reg;
      end
   end

   // a button level is taken once stable for the debounce time
   for (genvar b = 0; b < 2; b++) begin : g_deb
      always_ff @(posedge ref_clk) begin
         if (!rst_n) begin
            deb_cnt_reg[b] <= '0;
            deb_reg[b]     <= 1'b0;
         end else if (sync_reg[b] == deb_reg[b]) begin
            deb_cnt_reg[b] <= '0;
         end else if (deb_cnt_reg[b] >= CNT_W'(DEBOUNCE_T - 1)) begin
            deb_cnt_reg[b] <= '0;
            deb_reg[b]     <= sync_reg[b];
         end else begin
            deb_cnt_reg[b] <= deb_cnt_reg[b] + 1'b1;
         end
      end
   end

   wire bkp_btn  = deb_reg[0];
   wire rsel_btn = deb_reg[1];
   wire slot_ok  = sync_reg[2];
   wire pw_match = sync_reg[3];
   wire op_done  = sync_reg[4];

   // ********************************************************
   // avalon slave: one wait cycle, then the answer
   // ********************************************************
   logic              ack_reg;
   logic [31:0]       rdata_reg;
   logic [31:0]       pw_reg;
   logic [31:0]       newpw_reg;
   logic [7:0]        pwlen_reg;
   logic [VERIF_W-1:0] verif_reg;
   logic [31:0]       status_w;
   logic [31:0]       rd_mux;

   wire req     = avs_read | avs_write;
   wire wr_fire = avs_write & ack_reg;
   wire cmd_wr  = wr_fire & (avs_address == OFS_CMD);
   wire [3:0] cmd_code = avs_writedata[CMD_LSB +: 4];
   wire [ID_W-1:0] cmd_id = avs_writedata[ID_LSB +: ID_W];

   assign avs_waitrequest = req & ~ack_reg;
   assign avs_readdata    = rdata_reg;

   // unmapped reads answer zero, unmapped writes are dropped
   always_comb begin
      rd_mux = '0;
      unique case (avs_address)
         OFS_PWLEN:  rd_mux = {24'h000000, pwlen_reg};
         OFS_STATUS: rd_mux = status_w;
         OFS_VERIF:  rd_mux = {16'h0000, verif_reg};
         default:    rd_mux = '0;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ack_reg   <= 1'b0;
         rdata_reg <= '0;
      end else begin
         ack_reg <= req & ~ack_reg;
         if (avs_read & ~ack_reg)
            rdata_reg <= rd_mux;
      end
   end

   // password words are write only; they never read back
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pw_reg    <= '0;
         newpw_reg <= '0;
         pwlen_reg <= '0;
         verif_reg <= VERIF_RST;
      end else if (wr_fire) begin
         if (avs_address == OFS_PW)    pw_reg    <= avs_writedata;
         if (avs_address == OFS_NEWPW) newpw_reg <= avs_writedata;
         if (avs_address == OFS_PWLEN) pwlen_reg <= avs_writedata[7:0];
         if (avs_address == OFS_VERIF) verif_reg <= avs_writedata[VERIF_W-1:0];
      end
   end

   // ********************************************************
   // session access and password store
   // ********************************************************
   logic            pw_set_reg;
   logic [31:0]     pw_store_reg;
   logic            owner_reg;
   logic [ID_W-1:0] owner_id_reg;
   logic            project_reg;
   logic            err_reg;

   wire is_owner = owner_reg & (owner_id_reg == cmd_id);
   wire pw_ok    = pw_reg == pw_store_reg;
   wire len_ok   = pwlen_reg >= PW_MIN_LEN;
   wire con_ok   = ~owner_reg & (~pw_set_reg | pw_ok);
   wire set_ok   = is_owner & ~pw_set_reg & len_ok;
   wire chg_ok   = is_owner & pw_set_reg & pw_ok & len_ok;
   wire clr_ok   = is_owner & pw_set_reg & pw_ok;
   wire refresh  = cmd_wr & (cmd_code == CMD_FW_REFR);

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pw_set_reg   <= 1'b0;
         pw_store_reg <= '0;
         owner_reg    <= 1'b0;
         owner_id_reg <= '0;
      end else if (refresh) begin
         pw_set_reg   <= 1'b0;
         pw_store_reg <= '0;
         owner_reg    <= 1'b0;
      end else if (cmd_wr) begin
         if (cmd_code == CMD_CONNECT && con_ok) begin
            owner_reg    <= 1'b1;
            owner_id_reg <= cmd_id;
         end
         if (cmd_code == CMD_DISCON && is_owner)
            owner_reg <= 1'b0;
         if (cmd_code == CMD_SET_PW && set_ok) begin
            pw_set_reg   <= 1'b1;
            pw_store_reg <= pw_reg;
         end
         if (cmd_code == CMD_CHG_PW && chg_ok)
            pw_store_reg <= newpw_reg;
         if (cmd_code == CMD_CLR_PW && clr_ok)
            pw_set_reg <= 1'b0;
      end
   end

   // ********************************************************
   // backup and restore sequencer
   // ********************************************************
   brs_state_t       state_reg;
   brs_state_t       state_next;
   logic [CNT_W-1:0] hold_cnt_reg;
   logic [1:0]       settle_reg;
   logic             fw_reg;
   logic             shown_reg;
   logic             noback_on_reg;

   // software operations need an owning session and the module
   wire sw_ok   = cmd_wr & is_owner & slot_ok;
   wire sw_bkp  = sw_ok & (cmd_code == CMD_BACKUP || cmd_code == CMD_FW_BKUP);
   wire sw_rst  = sw_ok & (cmd_code == CMD_RESTORE);
   wire both    = bkp_btn & rsel_btn;
   wire hold_ok = hold_cnt_reg >= CNT_W'(RESTORE_T - 1);
   wire btn_bkp = bkp_btn & ~rsel_btn & slot_ok;
   wire rst_go  = ((both & hold_ok) | sw_rst) & pw_match;
   wire bkp_req = btn_bkp | sw_bkp;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_INIT:
            if (settle_reg == SETTLE_CYC)
               state_next = slot_ok ? ST_IDLE : ST_RUN;
         ST_RUN:
            state_next = ST_RUN;
         ST_IDLE:
            if (rst_go & slot_ok)
               state_next = ST_RESTORE;
            else if (bkp_req & cfg_verified)
               state_next = ST_BACKUP;
            else if (btn_bkp)
               state_next = ST_NOBACK;
         ST_BACKUP, ST_RESTORE:
            if (op_done)
               state_next = ST_IDLE;
         ST_NOBACK:
            if (!bkp_btn)
               state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_reg  <= ST_INIT;
         settle_reg <= '0;
      end else begin
         state_reg <= state_next;
         if (settle_reg != SETTLE_CYC)
            settle_reg <= settle_reg + 1'b1;
      end
   end

   // one counter times both the restore hold and the refusal wait
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         hold_cnt_reg  <= '0;
         noback_on_reg <= 1'b0;
      end else if (state_reg == ST_NOBACK) begin
         if (hold_cnt_reg >= CNT_W'(REFUSE_T - 1))
            noback_on_reg <= 1'b1;
         else
            hold_cnt_reg <= hold_cnt_reg + 1'b1;
      end else if (state_reg == ST_IDLE && both && !hold_ok) begin
         hold_cnt_reg <= hold_cnt_reg + 1'b1;
      end else if (!both || state_reg != ST_IDLE) begin
         hold_cnt_reg  <= '0;
         noback_on_reg <= 1'b0;
      end
   end

   // project, firmware selector and restored-digit flag
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         project_reg <= 1'b1;
         fw_reg      <= 1'b0;
         shown_reg   <= 1'b0;
         err_reg     <= 1'b0;
      end else begin
         if (refresh)
            project_reg <= 1'b0;
         else if (state_reg == ST_RESTORE && op_done)
            project_reg <= 1'b1;
         if (state_reg == ST_IDLE)
            fw_reg <= (state_next == ST_BACKUP) & sw_bkp & (cmd_code == CMD_FW_BKUP);
         if (state_reg == ST_RESTORE && op_done)
            shown_reg <= 1'b1;
         if (cmd_wr)
            err_reg <= (sw_rst | (both & hold_ok)) & ~pw_match;
         else if (state_reg == ST_IDLE && both && hold_ok)
            err_reg <= ~pw_match;                            // a good restore clears it
      end
   end

   // ********************************************************
   // indicators
   // ********************************************************
   logic [CNT_W-1:0] blink_cnt_reg;
   logic             blink_reg;
   logic [CNT_W-1:0] digit_cnt_reg;
   logic [1:0]       digit_reg;
   logic [IN_W-1:0]  in_reg;
   logic [OUT_W-1:0] out_reg;
   logic [7:0]       lamp_reg;
   logic [7:0]       lamp_next;

   wire fault_st = state_reg != ST_RUN && state_reg != ST_INIT;
   wire busy_st  = state_reg == ST_BACKUP || state_reg == ST_RESTORE;
   wire cycle_on = cfg_verified | shown_reg;
   wire [3:0] digit_val = verif_reg[4*digit_reg +: 4];

   // free-running blink and digit timers keep the rate steady
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         blink_cnt_reg <= '0;
         blink_reg     <= 1'b0;
         digit_cnt_reg <= '0;
         digit_reg     <= '0;
      end else begin
         blink_cnt_reg <= blink_cnt_reg + 1'b1;
         if (blink_cnt_reg >= CNT_W'(BLINK_T - 1)) begin
            blink_cnt_reg <= '0;
            blink_reg     <= ~blink_reg;
         end
         digit_cnt_reg <= digit_cnt_reg + 1'b1;
         if (digit_cnt_reg >= CNT_W'(DIGIT_T - 1)) begin
            digit_cnt_reg <= '0;
            digit_reg     <= digit_reg + 1'b1;
         end
      end
   end

   // lamp order: power, run, fault, lock, link, status, backup, restore
   always_comb begin
      lamp_next = {1'b1, 1'b0, 1'b1, 1'b1, 1'b0,
                   (busy_st & blink_reg) | noback_on_reg,
                   state_reg == ST_BACKUP, state_reg == ST_RESTORE};
      if (!fault_st)
         lamp_next = {1'b1, state_reg == ST_RUN && project_reg, 1'b0,
                      pw_set_reg, owner_reg, 3'h0};
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         lamp_reg <= '0;
         in_reg   <= '0;
         out_reg  <= '0;
      end else begin
         lamp_reg <= lamp_next;
         in_reg   <= '0;
         out_reg  <= '0;
         if (fault_st && cycle_on) begin
            in_reg  <= IN_W'(1) << digit_reg;
            out_reg <= {1'b0, digit_val};
         end else if (fault_st) begin
            in_reg  <= IN_UNVER;
            out_reg <= OUT_UNVER;
         end
      end
   end

   assign power_indicator         = lamp_reg[7];
   assign run_indicator           = lamp_reg[6];
   assign fault_indicator         = lamp_reg[5];
   assign lock_indicator          = lamp_reg[4];
   assign link_activity_indicator = lamp_reg[3];
   assign mod_status_led          = lamp_reg[2];
   assign mod_backup_req          = lamp_reg[1];
   assign mod_restore_req         = lamp_reg[0];
   assign mod_fw_incl             = fw_reg & mod_backup_req; // only while backup runs
   assign in_indicator            = in_reg;
   assign out_indicator           = out_reg;
   assign app_run                 = run_indicator;
   assign project_erase           = ~project_reg;

   // status word: state, password, owner, error, project, digits shown, owner id
   assign status_w = {16'h0000, owner_id_reg, shown_reg, project_reg,
                      err_reg, owner_reg, pw_set_reg, 3'(state_reg)};
endmodule

// ---- core/brs_pkg.sv ----
// constants and types shared by the backup and restore sequencer
package brs_pkg;
   // ********************************************************
   // clock and timing
   // ********************************************************
   localparam int unsigned CLK_HZ          = 20_000_000;
   localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
   localparam int unsigned REFUSE_MS       = 15000;
   localparam int unsigned RESTORE_HOLD_MS = 5000;
   localparam int unsigned DEBOUNCE_MS     = 10;
   localparam int unsigned DIGIT_MS        = 1000;
   localparam int unsigned BLINK_MS        = 250;
   localparam int unsigned REFUSE_CYC      = REFUSE_MS * CYC_PER_MS;
   localparam int unsigned RESTORE_CYC     = RESTORE_HOLD_MS * CYC_PER_MS;
   localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_MS * CYC_PER_MS;
   localparam int unsigned DIGIT_CYC       = DIGIT_MS * CYC_PER_MS;
   localparam int unsigned BLINK_CYC       = BLINK_MS * CYC_PER_MS;
   localparam logic [1:0]  SETTLE_CYC      = 2'h3;
   localparam int unsigned CNT_W           = 32;

   // ********************************************************
   // register map (byte addresses)
   // ********************************************************
   localparam int unsigned ADDR_W     = 8;
   localparam logic [7:0]  OFS_CMD    = 8'h00;
   localparam logic [7:0]  OFS_PW     = 8'h04;
   localparam logic [7:0]  OFS_NEWPW  = 8'h08;
   localparam logic [7:0]  OFS_PWLEN  = 8'h0c;
   localparam logic [7:0]  OFS_STATUS = 8'h10;
   localparam logic [7:0]  OFS_VERIF  = 8'h14;
   localparam int unsigned CMD_LSB    = 0;
   localparam int unsigned ID_LSB     = 8;
   localparam int unsigned ID_W       = 8;
   localparam logic [7:0]  PW_MIN_LEN = 8'h08;
   localparam int unsigned VERIF_W    = 16;
   localparam logic [15:0] VERIF_RST  = 16'h0000;
   localparam int unsigned IN_W       = 8;
   localparam int unsigned OUT_W      = 5;
   localparam logic [4:0]  OUT_UNVER  = 5'h1e;
   localparam logic [7:0]  IN_UNVER   = 8'h01;

   // ********************************************************
   // software commands and sequencer states
   // ********************************************************
   typedef enum logic [3:0] {
      CMD_NONE    = 4'h0,
      CMD_CONNECT = 4'h1,
      CMD_DISCON  = 4'h2,
      CMD_SET_PW  = 4'h3,
      CMD_CHG_PW  = 4'h4,
      CMD_CLR_PW  = 4'h5,
      CMD_FW_REFR = 4'h6,
      CMD_BACKUP  = 4'h7,
      CMD_FW_BKUP = 4'h8,
      CMD_RESTORE = 4'h9
   } brs_cmd_t;

   typedef enum logic [2:0] {
      ST_INIT, ST_RUN, ST_IDLE, ST_BACKUP, ST_NOBACK, ST_RESTORE
   } brs_state_t;
endpackage

// ---- testbench/brs_checker.sv ----
// port assertions for the backup and restore sequencer
`timescale 1ns/1ns
module brs_checker
   import brs_pkg::*;
#(
   parameter int unsigned REFUSE_T  = 200,
   parameter int unsigned RESTORE_T = 50,
   parameter int unsigned BLINK_T   = 4
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic backup_button,
   input wire logic restore_select_button,
   input wire logic slot1_present,
   input wire logic mod_done,
   input wire logic cfg_verified,
   input wire logic mod_backup_req,
   input wire logic mod_restore_req,
   input wire logic mod_fw_incl,
   input wire logic mod_status_led,
   input wire logic power_indicator,
   input wire logic run_indicator,
   input wire logic fault_indicator,
   input wire logic lock_indicator,
   input wire logic link_activity_indicator,
   input wire logic app_run
);
   logic [31:0] hold_cnt;
   logic [31:0] both_cnt;
   logic [31:0] still_cnt;
   logic        led_q;
   wire         busy = mod_backup_req | mod_restore_req;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // raw hold counters; debounce only adds slack, so lower bounds stay safe
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         hold_cnt  <= 32'h0;
         both_cnt  <= 32'h0;
         still_cnt <= 32'h0;
         led_q     <= 1'b0;
      end else begin
         hold_cnt  <= backup_button ? hold_cnt + 32'h1 : 32'h0;
         both_cnt  <= (backup_button && restore_select_button) ? both_cnt + 32'h1 : 32'h0;
         still_cnt <= (busy && mod_status_led == led_q) ? still_cnt + 32'h1 : 32'h0;
         led_q     <= mod_status_led;
      end
   end
   sequence s_start;
      $rose(mod_restore_req) && backup_button && restore_select_button;
   endsequence
   sequence s_drop;
      $fell(mod_backup_req) || $fell(mod_restore_req);
   endsequence
   property p_fault_lamps;
      fault_indicator |-> power_indicator && lock_indicator && !run_indicator
         && !link_activity_indicator;
   endproperty
   a_fault_lamps: assert property (p_fault_lamps) else $error("fault lamps wrong");
   property p_halted;
      fault_indicator |-> !app_run && !run_indicator;
   endproperty
   a_halted: assert property (p_halted) else $error("logic runs in fault");
   property p_verified;
      $rose(mod_backup_req) |-> $past(cfg_verified, 2);
   endproperty
   a_verified: assert property (p_verified) else $error("unverified backup");
   property p_slot;
      busy |-> slot1_present;
   endproperty
   a_slot: assert property (p_slot) else $error("operation without module");
   property p_done_ends;
      s_drop |-> $past(mod_done, 2);
   endproperty
   a_done_ends: assert property (p_done_ends) else $error("early end");
   property p_blink;
      busy |-> still_cnt <= BLINK_T + 2;
   endproperty
   a_blink: assert property (p_blink) else $error("status lamp not flashing");
   property p_refuse_wait;
      $rose(mod_status_led) && !busy |-> hold_cnt >= REFUSE_T;
   endproperty
   a_refuse_wait: assert property (p_refuse_wait) else $error("early refusal");
   property p_restore_hold;
      s_start |-> both_cnt >= RESTORE_T;
   endproperty
   a_restore_hold: assert property (p_restore_hold) else $error("short hold");
   property p_fw_sw;
      mod_fw_incl |-> mod_backup_req;
   endproperty
   a_fw_sw: assert property (p_fw_sw) else $error("firmware flag alone");
endmodule
bind brs_sequencer brs_checker #(.REFUSE_T(REFUSE_T), .RESTORE_T(RESTORE_T),
   .BLINK_T(BLINK_T)) brs_checker_inst (.*);

// ---- testbench/brs_mem_model.sv ----
// behavioural model of the plug-in backup memory module
`timescale 1ns/1ns
module brs_mem_model (
   input  wire logic       ref_clk,
   input  wire logic       backup_req,
   input  wire logic       restore_req,
   input  wire logic       pw_ok,
   input  wire logic [7:0] lat,
   output logic            mod_done,
   output logic            mod_pw_match
);
   logic [7:0] cnt;
   // stored password compare; a mismatch blocks restore
   assign mod_pw_match = pw_ok;
   // done after lat cycles, held until the request drops
   always @(posedge ref_clk) begin
      if (!(backup_req || restore_req)) begin
         cnt      <= 8'h00;
         mod_done <= 1'b0;
      end else if (cnt >= lat) begin
         mod_done <= 1'b1;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
endmodule

// ---- testbench/testbench.sv ----
// self-checking bench for the backup and restore sequencer
`timescale 1ns/1ns
module testbench
   import brs_pkg::*;
;
   localparam int unsigned R_T = 200, H_T = 50, D_T = 20;
   logic              ref_clk, rst_n, avs_read, avs_write, avs_waitrequest;
   logic [ADDR_W-1:0] avs_address;
   logic [31:0]       avs_writedata, avs_readdata, pa, pb;
   logic              backup_button, restore_select_button, slot1_present, cfg_verified;
   logic              mod_pw_match, mod_done, pw_ok, mod_backup_req, mod_restore_req;
   logic              mod_fw_incl, mod_status_led, power_indicator, run_indicator;
   logic              fault_indicator, lock_indicator, link_activity_indicator;
   logic              app_run, project_erase;
   logic [IN_W-1:0]   in_indicator;
   logic [OUT_W-1:0]  out_indicator;
   logic [7:0]        lat;
   logic [15:0]       verif;
   logic [31:0]       rd_mask[$], rd_exp[$];
   int                bad_count, check_count, n;

   brs_sequencer #(.REFUSE_T(R_T), .RESTORE_T(H_T), .DEBOUNCE_T(4), .DIGIT_T(D_T),
      .BLINK_T(4)) brs_sequencer_inst (.*);
   brs_mem_model brs_mem_model_inst (.ref_clk(ref_clk), .backup_req(mod_backup_req),
      .restore_req(mod_restore_req), .pw_ok(pw_ok), .lat(lat), .mod_done(mod_done),
      .mod_pw_match(mod_pw_match));

   // ****************************************
   // clock, checking and bus tasks
   // ****************************************
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // held until waitrequest low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= w;
      avs_read      <= ~w;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask
   task automatic expect_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      rd_mask.push_back(m);
      rd_exp.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic cmd(input logic [3:0] c, input logic [7:0] id);
      bus(1'b1, OFS_CMD, {16'h0, id, 4'h0, c});
   endtask
   // one-hot digit position and its nibble
   task automatic chk_digits;
      int i;
      for (int k = 0; k < 4; k++) begin
         repeat (2) @(negedge ref_clk);
         i = 0;
         while (i < 4 && in_indicator !== IN_W'(1 << i)) i++;
         check(in_indicator, IN_W'(1 << i));
         check(out_indicator, verif[i*4 +: 4]);
         repeat (D_T) @(posedge ref_clk);
      end
   endtask
   // read monitor
   always @(posedge ref_clk) begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && rd_exp.size() > 0) begin
         check(avs_readdata & rd_mask.pop_front(), rd_exp.pop_front());
      end
   end
   // watchdog
   initial begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      report_and_stop();
   end

   // ****************************************
   // test sequence
   // ****************************************
   initial begin
      {rst_n, avs_read, avs_write, backup_button, restore_select_button} = 5'h00;
      {avs_address, avs_writedata, cfg_verified, pw_ok, lat} = 0;
      slot1_present = 1'b1;
      void'($urandom(28517));
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (10) @(negedge ref_clk);
      check({power_indicator, run_indicator, fault_indicator, lock_indicator,
         link_activity_indicator, app_run}, 6'h2c);
      check({in_indicator, out_indicator}, {IN_UNVER, OUT_UNVER});
      expect_rd(OFS_STATUS, 32'h7, 32'h2);
      $display("test power_up done");
      backup_button <= 1'b1;
      repeat (R_T - 20) @(posedge ref_clk);
      check({mod_backup_req, mod_status_led}, 2'h0);
      repeat (60) @(posedge ref_clk);
      check({mod_backup_req, mod_status_led}, 2'h1);
      backup_button <= 1'b0;
      repeat (20) @(posedge ref_clk);
      $display("test refused_backup done");
      verif = 16'($urandom);
      bus(1'b1, OFS_VERIF, {16'h0, verif});
      cfg_verified <= 1'b1;
      chk_digits();
      // prompt and slow module answers
      for (int k = 0; k < 2; k++) begin
         lat <= k ? 8'h50 : 8'h10;
         backup_button <= 1'b1;
         for (n = 0; n < 100 && mod_backup_req !== 1'b1; n++) @(posedge ref_clk);
         check(mod_backup_req, 1'b1);
         backup_button <= 1'b0;
         for (n = 0; n < 200 && mod_backup_req !== 1'b0; n++) @(posedge ref_clk);
         repeat (3) @(posedge ref_clk);
         check({mod_backup_req, mod_fw_incl, mod_status_led}, 3'h0);
      end
      $display("test button_backup done");
      // short hold, mismatch, restore
      for (int k = 0; k < 3; k++) begin
         pw_ok <= (k != 1);
         restore_select_button <= 1'b1;
         repeat (10) @(posedge ref_clk);
         backup_button <= 1'b1;
         for (n = 0; n < (k ? 100 : 30) && mod_restore_req !== 1'b1; n++) @(posedge ref_clk);
         backup_button <= 1'b0;
         check(mod_restore_req, k == 2);
         if (k == 2) begin
            check(n >= H_T, 1'b1);
            repeat (30) @(posedge ref_clk);
            check(mod_restore_req, 1'b1);
            for (n = 0; n < 200 && mod_restore_req !== 1'b0; n++) @(posedge ref_clk);
            repeat (3) @(posedge ref_clk);
            check(mod_status_led, 1'b0);
            chk_digits();
            expect_rd(OFS_STATUS, 32'ha0, 32'h80);
         end
         restore_select_button <= 1'b0;
         repeat (20) @(posedge ref_clk);
         if (k == 1) expect_rd(OFS_STATUS, 32'h20, 32'h20);
      end
      $display("test restore done");
      pa = $urandom;
      pb = ~pa;
      cmd(4'h1, 8'h01);
      cmd(4'h1, 8'h02);
      expect_rd(OFS_STATUS, 32'hff18, 32'h0110);
      bus(1'b1, OFS_PWLEN, 32'h7);
      bus(1'b1, OFS_PW, pa);
      cmd(4'h3, 8'h01);
      expect_rd(OFS_STATUS, 32'h8, 32'h0);
      bus(1'b1, OFS_PWLEN, 32'h8);
      cmd(4'h3, 8'h01);
      expect_rd(OFS_STATUS, 32'h8, 32'h8);
      cmd(4'h2, 8'h01);
      bus(1'b1, OFS_PW, pb);
      cmd(4'h1, 8'h02);
      expect_rd(OFS_STATUS, 32'h10, 32'h0);
      bus(1'b1, OFS_PW, pa);
      cmd(4'h1, 8'h02);
      expect_rd(OFS_STATUS, 32'hff18, 32'h0218);
      bus(1'b1, OFS_NEWPW, pb);
      cmd(4'h4, 8'h02);
      cmd(4'h2, 8'h02);
      cmd(4'h1, 8'h03);
      expect_rd(OFS_STATUS, 32'h10, 32'h0);
      bus(1'b1, OFS_PW, pb);
      cmd(4'h1, 8'h03);
      expect_rd(OFS_STATUS, 32'hff18, 32'h0318);
      cmd(4'h5, 8'h03);
      cmd(4'h2, 8'h03);
      bus(1'b1, OFS_PW, pa);
      cmd(4'h1, 8'h04);
      expect_rd(OFS_STATUS, 32'hff18, 32'h0410);
      expect_rd(8'h3c, 32'hffffffff, 32'h0);
      cmd(4'h8, 8'h04);
      for (n = 0; n < 100 && mod_fw_incl !== 1'b1; n++) @(posedge ref_clk);
      check(mod_fw_incl, 1'b1);
      for (n = 0; n < 300 && mod_backup_req !== 1'b0; n++) @(posedge ref_clk);
      cmd(4'h6, 8'h00);
      expect_rd(OFS_STATUS, 32'h58, 32'h0);
      check(project_erase, 1'b1);
      $display("test sessions done");
      report_and_stop();
   end
endmodule
